// >>> design/p0h_pkg.sv
// Purpose: shared constants and types for the port-0 high pin control block
// Assumes: 8-bit cpu data path, byte addresses of the cpu data space
// Notes: design register offsets, field positions and reset values live here; monitor and tb repeat offsets and mask as literals
package p0h_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] P0H_ADDR_HIGH_CFG = 8'hc6;
  localparam logic [7:0] P0H_ADDR_PULLUP = 8'hc9;
  localparam logic [7:0] P0H_HIGH_CFG_RESET = 8'h00;
  localparam logic [7:0] P0H_PULLUP_RESET = 8'h00;
  localparam logic [7:0] P0H_HIGH_CFG_WMASK = 8'hfd;

  // ----------------------------------------------------------------
  // field positions in the high config register
  // ----------------------------------------------------------------
  localparam int P0H_SEVEN_LSB = 5;
  localparam int P0H_SIX_LSB = 2;
  localparam int P0H_FIVE_PP_BIT = 0;
  localparam int P0H_FIELD_W = 3;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] P0H_F_SCHMITT = 3'h0;
  localparam logic [2:0] P0H_F_OPEN_DRAIN = 3'h1;
  localparam logic [2:0] P0H_F_ANALOG = 3'h2;
  localparam logic [2:0] P0H_F_PERIPH = 3'h3;
  localparam logic [1:0] P0H_M_SCHMITT = 2'h0;
  localparam logic [1:0] P0H_M_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] P0H_M_ANALOG = 2'h2;

  typedef enum logic [2:0] {
    P0H_MODE_SCHMITT,
    P0H_MODE_OPEN_DRAIN,
    P0H_MODE_ANALOG,
    P0H_MODE_PERIPH,
    P0H_MODE_PUSH_PULL
  } p0h_mode_e;

  // per-pin control bundle handed to the pad
  typedef struct packed {
    logic schmitt_in;
    logic open_drain;
    logic push_pull;
    logic analog_alt;
    logic periph_alt;
  } p0h_pin_ctrl_s;

endpackage : p0h_pkg

// >>> design/p0h_mode_dec.sv
// Purpose: decode one pin's mode into control bundle
// Assumes: purely combinational, used per pin by the top
// Notes: pin five passes a synthetic 3-bit field built by the top
`timescale 1ns/1ps
`default_nettype none
module p0h_mode_dec (
  input wire logic [2:0] i_field,
  output p0h_pkg::p0h_pin_ctrl_s o_ctrl,
  output p0h_pkg::p0h_mode_e o_mode
);

  always_comb begin
    o_ctrl = '0;
    if (i_field[2]) begin
      o_mode = p0h_pkg::P0H_MODE_PUSH_PULL;
    end else begin
      unique case (i_field)
        p0h_pkg::P0H_F_SCHMITT: o_mode = p0h_pkg::P0H_MODE_SCHMITT;
        p0h_pkg::P0H_F_OPEN_DRAIN: o_mode = p0h_pkg::P0H_MODE_OPEN_DRAIN;
        p0h_pkg::P0H_F_ANALOG: o_mode = p0h_pkg::P0H_MODE_ANALOG;
        default: o_mode = p0h_pkg::P0H_MODE_PERIPH;
      endcase
    end
    o_ctrl.schmitt_in = (o_mode == p0h_pkg::P0H_MODE_SCHMITT);
    o_ctrl.open_drain = (o_mode == p0h_pkg::P0H_MODE_OPEN_DRAIN);
    o_ctrl.push_pull = (o_mode == p0h_pkg::P0H_MODE_PUSH_PULL);
    o_ctrl.analog_alt = (o_mode == p0h_pkg::P0H_MODE_ANALOG);
    o_ctrl.periph_alt = (o_mode == p0h_pkg::P0H_MODE_PERIPH);
  end

endmodule : p0h_mode_dec
`default_nettype wire

// >>> design/p0h_pin_ctrl.sv
// Purpose: high pin control register and pad steering for port-0 pins seven to five
// Assumes: cpu strobes and pin inputs synchronous to i_sys_clk
// Notes: index 0 of the 3-bit pin vectors is pin five, index 2 is pin seven
`timescale 1ns/1ps
`default_nettype none
module p0h_pin_ctrl (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [1:0] i_mid_pin5_mode,
  input wire logic [2:0] i_port_data,
  input wire logic [2:0] i_periph_out,
  input wire logic [2:0] i_pin_in,
  output logic [7:0] o_cpu_rdata,
  output logic [7:0] o_pullup_en,
  output p0h_pkg::p0h_pin_ctrl_s [2:0] o_pin_ctrl,
  output logic [2:0] o_pin_out,
  output logic [2:0] o_pin_oe,
  output logic [2:0] o_pin_in_data
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] high_cfg_q;
  logic [7:0] high_cfg_d;
  logic [7:0] pullup_q;
  logic [7:0] pullup_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    high_cfg_d = high_cfg_q;
    pullup_d = pullup_q;
    rdata_d = rdata_q;
    if (i_cpu_wr && i_cpu_addr == p0h_pkg::P0H_ADDR_HIGH_CFG) begin
      high_cfg_d = i_cpu_wdata & p0h_pkg::P0H_HIGH_CFG_WMASK;
    end
    if (i_cpu_wr && i_cpu_addr == p0h_pkg::P0H_ADDR_PULLUP) begin
      pullup_d = i_cpu_wdata;
    end
    if (i_cpu_rd) begin
      unique case (i_cpu_addr)
        p0h_pkg::P0H_ADDR_HIGH_CFG: rdata_d = high_cfg_q & p0h_pkg::P0H_HIGH_CFG_WMASK;
        p0h_pkg::P0H_ADDR_PULLUP: rdata_d = pullup_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      high_cfg_q <= p0h_pkg::P0H_HIGH_CFG_RESET;
      pullup_q <= p0h_pkg::P0H_PULLUP_RESET;
      rdata_q <= 8'h00;
    end else begin
      high_cfg_q <= high_cfg_d;
      pullup_q <= pullup_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  // pin five has only a force bit here; otherwise its 2-bit mid field is
  // widened so the shared decoder sees the same codes as pins six and seven
  logic [2:0] field [3];
  p0h_pkg::p0h_pin_ctrl_s ctrl_c [3];
  p0h_pkg::p0h_mode_e mode_c [3];

  always_comb begin
    field[2] = high_cfg_q[p0h_pkg::P0H_SEVEN_LSB +: p0h_pkg::P0H_FIELD_W];
    field[1] = high_cfg_q[p0h_pkg::P0H_SIX_LSB +: p0h_pkg::P0H_FIELD_W];
    if (high_cfg_q[p0h_pkg::P0H_FIVE_PP_BIT]) begin
      field[0] = 3'h4;
    end else begin
      field[0] = {1'b0, i_mid_pin5_mode};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pin
      p0h_mode_dec u_dec (
        .i_field(field[g]),
        .o_ctrl(ctrl_c[g]),
        .o_mode(mode_c[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad steering
  // ----------------------------------------------------------------
  // peripheral alternative only routes the pad; the peripheral itself
  // must be enabled separately or i_periph_out just sits idle
  p0h_pkg::p0h_pin_ctrl_s [2:0] pin_ctrl_q;
  p0h_pkg::p0h_pin_ctrl_s [2:0] pin_ctrl_d;
  logic [2:0] pin_out_q;
  logic [2:0] pin_out_d;
  logic [2:0] pin_oe_q;
  logic [2:0] pin_oe_d;
  logic [2:0] pin_in_q;
  logic [2:0] pin_in_d;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_ctrl_d[i] = ctrl_c[i];
      pin_out_d[i] = 1'b0;
      pin_oe_d[i] = 1'b0;
      unique case (mode_c[i])
        p0h_pkg::P0H_MODE_PUSH_PULL: begin
          pin_out_d[i] = i_port_data[i];
          pin_oe_d[i] = 1'b1;
        end
        p0h_pkg::P0H_MODE_OPEN_DRAIN: begin
          pin_oe_d[i] = ~i_port_data[i];
        end
        p0h_pkg::P0H_MODE_PERIPH: begin
          pin_out_d[i] = i_periph_out[i];
          pin_oe_d[i] = 1'b1;
        end
        p0h_pkg::P0H_MODE_ANALOG: begin
          pin_oe_d[i] = 1'b0;
        end
        p0h_pkg::P0H_MODE_SCHMITT: begin
          pin_oe_d[i] = 1'b0;
        end
      endcase
    end
    // analog pins keep the digital input quiet to avoid crowbar current
    for (int i = 0; i < 3; i++) begin
      pin_in_d[i] = ctrl_c[i].analog_alt ? 1'b0 : i_pin_in[i];
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_ctrl_q <= '0;
      pin_out_q <= 3'h0;
      pin_oe_q <= 3'h0;
      pin_in_q <= 3'h0;
    end else begin
      pin_ctrl_q <= pin_ctrl_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pin_in_q <= pin_in_d;
    end
  end

  assign o_cpu_rdata = rdata_q;
  assign o_pullup_en = pullup_q;
  assign o_pin_ctrl = pin_ctrl_q;
  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_pin_in_data = pin_in_q;

endmodule : p0h_pin_ctrl
`default_nettype wire

// >>> sim/p0h_pin_ctrl_monitor.sv
// Purpose: port checks for the port-0 high pin control block
// Assumes: one clock, async active-high reset
// Notes: mode table rebuilt here, not shared with the design
`timescale 1ns/1ps
`default_nettype none
module p0h_pin_ctrl_monitor (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_cpu_addr,
  input wire logic [7:0] i_cpu_wdata,
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [1:0] i_mid_pin5_mode,
  input wire logic [7:0] o_cpu_rdata,
  input wire logic [7:0] o_pullup_en,
  input wire p0h_pkg::p0h_pin_ctrl_s [2:0] o_pin_ctrl
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  function automatic logic [4:0] dec(input logic [2:0] f);
    if (f[2]) return 5'h04;
    case (f[1:0])
      2'h0: return 5'h10;
      2'h1: return 5'h08;
      2'h2: return 5'h02;
      default: return 5'h01;
    endcase
  endfunction : dec
  sequence s_cfg_wr;
    i_cpu_wr && i_cpu_addr == 8'hc6;
  endsequence
  sequence s_cfg_rd;
    i_cpu_rd && !i_cpu_wr && i_cpu_addr == 8'hc6;
  endsequence
  a_reset_inputs: assert property ($fell(i_reset) |=> o_pin_ctrl[2] == 5'h10)
    else $error("pin seven not input after reset");
  a_seven_decode: assert property (s_cfg_wr |=> ##1 o_pin_ctrl[2] == dec($past(i_cpu_wdata[7:5], 2)))
    else $error("pin seven mode wrong");
  a_five_forced: assert property (s_cfg_wr ##0 i_cpu_wdata[0] |=> ##1 o_pin_ctrl[0] == 5'h04)
    else $error("pin five not push-pull");
  a_five_mid: assert property (s_cfg_wr ##0 !i_cpu_wdata[0] ##1 !i_cpu_wr
    |=> o_pin_ctrl[0] == dec({1'b0, $past(i_mid_pin5_mode)}))
    else $error("pin five mode wrong");
  a_read_back: assert property (s_cfg_wr ##1 !i_cpu_wr ##1 s_cfg_rd
    |=> o_cpu_rdata == ($past(i_cpu_wdata, 3) & 8'hfd))
    else $error("config read back wrong");
  a_bit_one: assert property (s_cfg_rd |=> !o_cpu_rdata[1])
    else $error("unused bit reads one");
  a_pullup_write: assert property (i_cpu_wr && i_cpu_addr == 8'hc9 |=> o_pullup_en == $past(i_cpu_wdata))
    else $error("pull-up enables wrong");
endmodule : p0h_pin_ctrl_monitor
bind p0h_pin_ctrl p0h_pin_ctrl_monitor mon_u (.i_sys_clk, .i_reset, .i_cpu_addr, .i_cpu_wdata, .i_cpu_wr,
  .i_cpu_rd, .i_mid_pin5_mode, .o_cpu_rdata, .o_pullup_en, .o_pin_ctrl);
`default_nettype wire

// >>> sim/tb.sv
// Purpose: directed register and pad test of the port-0 high pin control block
// Assumes: 10 MHz clock, accesses spaced by one idle cycle, or two in the mode loops
// Notes: pad expectations assume port data 101, peripheral out 010
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_sys_clk = 1'b0, i_reset = 1'b1, i_cpu_wr = 1'b0, i_cpu_rd = 1'b0;
  logic [7:0] i_cpu_addr = 8'h00, i_cpu_wdata = 8'h00, o_cpu_rdata, o_pullup_en;
  logic [1:0] i_mid_pin5_mode = 2'h0;
  // periph out stands in for a peripheral that software has enabled
  logic [2:0] i_port_data = 3'h5, i_periph_out = 3'h2, i_pin_in = 3'h7, o_pin_out, o_pin_oe, o_pin_in_data;
  p0h_pkg::p0h_pin_ctrl_s [2:0] o_pin_ctrl;
  int errors = 0, comparisons = 0;
  p0h_pin_ctrl dut_u (.i_sys_clk, .i_reset, .i_cpu_addr, .i_cpu_wdata, .i_cpu_wr, .i_cpu_rd, .i_mid_pin5_mode,
    .i_port_data, .i_periph_out, .i_pin_in, .o_cpu_rdata, .o_pullup_en, .o_pin_ctrl, .o_pin_out, .o_pin_oe,
    .o_pin_in_data);
  initial forever #50 i_sys_clk = ~i_sys_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_cpu_addr <= a;
    i_cpu_wdata <= d;
    i_cpu_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_cpu_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_cpu_addr <= a;
    i_cpu_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_cpu_rd <= 1'b0;
    #1;
    check(o_cpu_rdata, e, "read data");
  endtask : rd
  function automatic logic [7:0] dec(input logic [2:0] f);
    if (f[2]) return 8'h04;
    return 8'h10 >> (f[1:0] == 2'h3 ? 4 : f[1:0] == 2'h2 ? 3 : f[1:0]);
  endfunction : dec
  // hang guard, all waits below are fixed by the access timing
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    errors++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    check({3'h0, o_pin_ctrl[2]}, 8'h10, "pin seven after reset");
    check({3'h0, o_pin_ctrl[1]}, 8'h10, "pin six after reset");
    rd(8'hc6, 8'h00);
    rd(8'hc9, 8'h00);
    wr(8'hc6, 8'hff);
    rd(8'hc6, 8'hfd);
    wr(8'hc9, 8'ha5);
    rd(8'hc9, 8'ha5);
    check(o_pullup_en, 8'ha5, "pull-up enables");
    wr(8'h40, 8'h5a);
    rd(8'h40, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'hc6, {c[2:0], ~c[2:0], 1'b0, c[0]});
      @(posedge i_sys_clk);
      #1;
      check({3'h0, o_pin_ctrl[2]}, dec(c[2:0]), "pin seven mode");
      check({3'h0, o_pin_ctrl[1]}, dec(~c[2:0]), "pin six mode");
      check({5'h0, o_pin_oe[2], o_pin_out[2], o_pin_in_data[2]}, {5'h0, c > 2, c > 3, c != 2}, "pin seven pad");
      check({5'h0, o_pin_oe[1], o_pin_out[1], o_pin_in_data[1]}, {5'h0, c != 5 && c != 7, c == 4, c != 5},
        "pin six pad");
      check({3'h0, o_pin_ctrl[0]}, c[0] ? 8'h04 : 8'h10, "pin five mode");
      check({5'h0, o_pin_oe[0], o_pin_out[0], o_pin_in_data[0]}, {5'h0, c[0], c[0], 1'b1}, "pin five pad");
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'hc6, 8'h00);
      i_mid_pin5_mode <= m[1:0];
      @(posedge i_sys_clk);
      #1;
      check({3'h0, o_pin_ctrl[0]}, dec({1'b0, m[1:0]}), "pin five mid mode");
      check({5'h0, o_pin_oe[0], o_pin_out[0], o_pin_in_data[0]}, {5'h0, m == 3, 1'b0, m != 2}, "pin five mid pad");
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
